// *** core/kcgrc_consts.svh ***
`ifndef KCGRC_CONSTS_SVH
`define KCGRC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define KCGRC_OFF_DATA       8'h00
`define KCGRC_OFF_CMD        8'h04
`define KCGRC_OFF_FW         8'h08
`define KCGRC_OFF_FAST_PORT  8'h0c
`define KCGRC_OFF_FAST_CTL   8'hf0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define KCGRC_CTL_RATE_HI    7
`define KCGRC_CTL_RATE_LO    6
`define KCGRC_CTL_PORT_EN    2
`define KCGRC_CTL_HW_GATE    1
`define KCGRC_CTL_HW_RST     0
`define KCGRC_CTL_WMASK      8'hc7
`define KCGRC_GATE_BIT       1
`define KCGRC_RST_BIT        0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define KCGRC_CTL_RESET      8'h00
`define KCGRC_PORT_RESET     8'h24
`define KCGRC_PORT_FIXED     8'h24
`define KCGRC_PORT_WMASK     8'h03
`define KCGRC_FW_RESET       8'h01
`define KCGRC_TWO_RESET      8'h01

// ----------------------------------------------------------------------
// Host commands
// ----------------------------------------------------------------------
`define KCGRC_CMD_IF_TEST    8'hab
`define KCGRC_CMD_RD_ONE     8'hc0
`define KCGRC_CMD_POLL_LO    8'hc1
`define KCGRC_CMD_POLL_HI    8'hc2
`define KCGRC_CMD_RD_TWO     8'hd0
`define KCGRC_CMD_WR_TWO     8'hd1
`define KCGRC_CMD_KB_ECHO    8'hd2
`define KCGRC_CMD_AUX_ECHO   8'hd3
`define KCGRC_CMD_AUX_FWD    8'hd4
`define KCGRC_CMD_RD_TEST    8'he0
`define KCGRC_CMD_PULSE_HI   4'hf
`define KCGRC_CMD_HW_RESET   8'hfe

// ----------------------------------------------------------------------
// Interface test result codes
// ----------------------------------------------------------------------
`define KCGRC_TST_OK         8'h00
`define KCGRC_TST_CLK_LOW    8'h01
`define KCGRC_TST_CLK_HIGH   8'h02
`define KCGRC_TST_DAT_LOW    8'h03
`define KCGRC_TST_DAT_HIGH   8'h04

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define KCGRC_CLK_MHZ        200
`define KCGRC_RST_DELAY_US   14
`define KCGRC_RST_PULSE_US   6
`define KCGRC_RST_DELAY_CYC  (`KCGRC_RST_DELAY_US * `KCGRC_CLK_MHZ)
`define KCGRC_RST_PULSE_CYC  (`KCGRC_RST_PULSE_US * `KCGRC_CLK_MHZ)
`define KCGRC_TEST_SETTLE    4'h8

`endif

// *** core/kcgrc_pkg.sv ***
package kcgrc_pkg;

	// Synchronised pin group
	typedef struct packed {
		logic [7:0] port_one;
		logic [1:0] test_in;
		logic       kclk;
		logic       kdat;
	} kcgrc_pins_t;

	// Byte handed to a serial link
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} kcgrc_byte_t;

	// What the next data byte means
	typedef enum logic [2:0] {
		KCGRC_EXP_NONE,
		KCGRC_EXP_TWO,
		KCGRC_EXP_KB_ECHO,
		KCGRC_EXP_AUX_ECHO,
		KCGRC_EXP_AUX_FWD
	} kcgrc_expect_t;

	// Status nibble polling
	typedef enum logic [1:0] {
		KCGRC_POLL_NONE,
		KCGRC_POLL_LO,
		KCGRC_POLL_HI
	} kcgrc_poll_t;

	// Interface test engine
	typedef enum logic {
		KCGRC_TST_IDLE,
		KCGRC_TST_RUN
	} kcgrc_tst_t;

endpackage

// *** core/kcgrc_top.sv ***
// The APB interface to the registers is this design's own decision.

`include "kcgrc_consts.svh"

module kcgrc_top (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  reset_n,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Pins from outside, asynchronous
	input  wire kcgrc_pkg::kcgrc_pins_t pins_in,
	// Keyboard lines, open drain (out is always low)
	output logic                       kclk_out,
	output logic                       kclk_oe,
	output logic                       kdat_out,
	output logic                       kdat_oe,
	// Bytes towards the serial links
	output kcgrc_pkg::kcgrc_byte_t     kb_tx,
	output kcgrc_pkg::kcgrc_byte_t     aux_tx,
	// System control outputs
	output logic [1:0]                 clk_rate_sel,
	output logic                       addr_line20_gate,
	output logic                       keyboard_reset_out,
	output logic                       reset_line
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	kcgrc_pkg::kcgrc_pins_t  pins_s1_r;
	kcgrc_pkg::kcgrc_pins_t  pins_s2_r;
	kcgrc_pkg::kcgrc_expect_t expect_r;
	kcgrc_pkg::kcgrc_poll_t  poll_r;
	kcgrc_pkg::kcgrc_tst_t   tst_r;
	logic                    pready_r;
	logic [7:0]              fast_ctl_r;
	logic [7:0]              fast_port_r;
	logic [7:0]              fw_r;
	logic [7:0]              port_two_r;
	logic [7:0]              obuf_r;
	logic                    obf_r;
	logic                    aux_obf_r;
	logic                    cmd_flag_r;
	logic [1:0]              tst_phase_r;
	logic [3:0]              tst_cnt_r;
	logic                    tst_done_r;
	logic [7:0]              tst_res_r;
	logic                    acc;
	logic                    wr_fire;
	logic                    rd_fire;
	logic                    cmd_wr;
	logic                    data_wr;
	logic [7:0]              wbyte;
	logic                    hit_data;
	logic                    hit_cmd;
	logic                    hit_fw;
	logic                    hit_port;
	logic                    hit_ctl;
	logic [7:0]              status;
	logic [7:0]              rd_mux;
	logic                    obuf_load;
	logic                    obuf_aux;
	logic [7:0]              obuf_val;
	logic [2:0]              pulse_trig;
	logic [2:0]              pulse_low;
	logic                    gate_nxt;
	logic                    rst_low_nxt;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	// Two stages; only the second stage is read by logic
	always_ff @(posedge mclk) begin
		pins_s1_r <= pins_in;
		pins_s2_r <= pins_s1_r;
	end

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// One wait state so read data and pready come straight from flops
	assign acc      = psel & penable;
	assign wr_fire  = acc & pready_r & pwrite;
	assign rd_fire  = acc & pready_r & ~pwrite;
	assign wbyte    = pwdata[7:0];
	assign hit_data = (paddr == `KCGRC_OFF_DATA);
	assign hit_cmd  = (paddr == `KCGRC_OFF_CMD);
	assign hit_fw   = (paddr == `KCGRC_OFF_FW);
	assign hit_port = (paddr == `KCGRC_OFF_FAST_PORT);
	assign hit_ctl  = (paddr == `KCGRC_OFF_FAST_CTL);
	assign cmd_wr   = wr_fire & hit_cmd;
	assign data_wr  = wr_fire & hit_data;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= acc & ~pready_r;
		end
	end

	// Status layout: polled nibble replaces the upper half while polling
	always_comb begin
		status = {1'b0, 1'b0, aux_obf_r, 1'b1, cmd_flag_r, 1'b0, 1'b0, obf_r};
		unique case (poll_r)
			kcgrc_pkg::KCGRC_POLL_LO:   status[7:4] = pins_s2_r.port_one[3:0];
			kcgrc_pkg::KCGRC_POLL_HI:   status[7:4] = pins_s2_r.port_one[7:4];
			kcgrc_pkg::KCGRC_POLL_NONE: status[7:4] = {2'b00, aux_obf_r, 1'b1};
		endcase
	end

	// Read mux; unmapped addresses read zero and flag an error
	always_comb begin
		rd_mux = 8'h00;
		if (hit_data) begin
			rd_mux = obuf_r;
		end else if (hit_cmd) begin
			rd_mux = status;
		end else if (hit_fw) begin
			rd_mux = fw_r;
		end else if (hit_port) begin
			rd_mux = fast_port_r;
		end else if (hit_ctl) begin
			rd_mux = fast_ctl_r;
		end
	end

	// Answer registered in the first access cycle
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (acc & ~pready_r) begin
			prdata  <= {24'h00_0000, rd_mux};
			pslverr <= ~(hit_data | hit_cmd | hit_fw | hit_port | hit_ctl);
		end else begin
			pslverr <= 1'b0;
		end
	end

	assign pready = pready_r;

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	// Reserved control bits are masked so they read zero
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fast_ctl_r <= `KCGRC_CTL_RESET;
		end else if (wr_fire & hit_ctl) begin
			fast_ctl_r <= wbyte & `KCGRC_CTL_WMASK;
		end
	end

	// Fixed bits always forced back in
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fast_port_r <= `KCGRC_PORT_RESET;
		end else if (wr_fire & hit_port) begin
			fast_port_r <= `KCGRC_PORT_FIXED | (wbyte & `KCGRC_PORT_WMASK);
		end
	end

	// Firmware-owned gate and reset levels
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fw_r <= `KCGRC_FW_RESET;
		end else if (wr_fire & hit_fw) begin
			fw_r <= wbyte;
		end
	end

	// ------------------------------------------------------------------
	// Command decoder
	// ------------------------------------------------------------------
	// Any command cancels a pending data phase and polling
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			expect_r <= kcgrc_pkg::KCGRC_EXP_NONE;
		end else if (cmd_wr) begin
			unique case (wbyte)
				`KCGRC_CMD_WR_TWO:   expect_r <= kcgrc_pkg::KCGRC_EXP_TWO;
				`KCGRC_CMD_KB_ECHO:  expect_r <= kcgrc_pkg::KCGRC_EXP_KB_ECHO;
				`KCGRC_CMD_AUX_ECHO: expect_r <= kcgrc_pkg::KCGRC_EXP_AUX_ECHO;
				`KCGRC_CMD_AUX_FWD:  expect_r <= kcgrc_pkg::KCGRC_EXP_AUX_FWD;
				default:             expect_r <= kcgrc_pkg::KCGRC_EXP_NONE;
			endcase
		end else if (data_wr) begin
			expect_r <= kcgrc_pkg::KCGRC_EXP_NONE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			poll_r <= kcgrc_pkg::KCGRC_POLL_NONE;
		end else if (cmd_wr) begin
			if (wbyte == `KCGRC_CMD_POLL_LO) begin
				poll_r <= kcgrc_pkg::KCGRC_POLL_LO;
			end else if (wbyte == `KCGRC_CMD_POLL_HI) begin
				poll_r <= kcgrc_pkg::KCGRC_POLL_HI;
			end else begin
				poll_r <= kcgrc_pkg::KCGRC_POLL_NONE;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cmd_flag_r <= 1'b0;
		end else if (cmd_wr | data_wr) begin
			cmd_flag_r <= cmd_wr;
		end
	end

	// Second port: data after the gate command lands here
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			port_two_r <= `KCGRC_TWO_RESET;
		end else if (data_wr & (expect_r == kcgrc_pkg::KCGRC_EXP_TWO)) begin
			port_two_r <= wbyte;
		end
	end

	// ------------------------------------------------------------------
	// Output buffer
	// ------------------------------------------------------------------
	// A command in the same cycle as a test result wins; the host is
	// expected to wait for the test answer before issuing more.
	always_comb begin
		obuf_load = 1'b0;
		obuf_aux  = 1'b0;
		obuf_val  = 8'h00;
		if (cmd_wr) begin
			if (wbyte == `KCGRC_CMD_RD_ONE) begin
				obuf_load = 1'b1;
				obuf_val  = pins_s2_r.port_one;
			end else if (wbyte == `KCGRC_CMD_RD_TWO) begin
				obuf_load = 1'b1;
				obuf_val  = port_two_r;
			end else if (wbyte == `KCGRC_CMD_RD_TEST) begin
				obuf_load = 1'b1;
				obuf_val  = {6'h00, pins_s2_r.test_in};
			end
		end else if (data_wr & (expect_r == kcgrc_pkg::KCGRC_EXP_KB_ECHO)) begin
			obuf_load = 1'b1;
			obuf_val  = wbyte;
		end else if (data_wr & (expect_r == kcgrc_pkg::KCGRC_EXP_AUX_ECHO)) begin
			obuf_load = 1'b1;
			obuf_aux  = 1'b1;
			obuf_val  = wbyte;
		end else if (tst_done_r) begin
			obuf_load = 1'b1;
			obuf_val  = tst_res_r;
		end
	end

	// Reading the data port empties the buffer; a load in that cycle wins
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			obuf_r    <= 8'h00;
			obf_r     <= 1'b0;
			aux_obf_r <= 1'b0;
		end else if (obuf_load) begin
			obuf_r    <= obuf_val;
			obf_r     <= 1'b1;
			aux_obf_r <= obuf_aux;
		end else if (rd_fire & hit_data) begin
			obf_r     <= 1'b0;
			aux_obf_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Link bytes
	// ------------------------------------------------------------------
	// One-cycle valid; plain data goes to the keyboard
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			kb_tx  <= '0;
			aux_tx <= '0;
		end else begin
			kb_tx.valid  <= data_wr & (expect_r == kcgrc_pkg::KCGRC_EXP_NONE);
			aux_tx.valid <= data_wr & (expect_r == kcgrc_pkg::KCGRC_EXP_AUX_FWD);
			if (data_wr) begin
				kb_tx.data  <= wbyte;
				aux_tx.data <= wbyte;
			end
		end
	end

	// ------------------------------------------------------------------
	// Interface test engine
	// ------------------------------------------------------------------
	// Phases: clock released, clock pulled, data released, data pulled.
	// Each waits a settle time covering the two-stage synchroniser.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tst_r       <= kcgrc_pkg::KCGRC_TST_IDLE;
			tst_phase_r <= 2'd0;
			tst_cnt_r   <= 4'h0;
			tst_done_r  <= 1'b0;
			tst_res_r   <= `KCGRC_TST_OK;
			kclk_oe     <= 1'b0;
			kdat_oe     <= 1'b0;
		end else begin
			tst_done_r <= 1'b0;
			unique case (tst_r)
				kcgrc_pkg::KCGRC_TST_IDLE: begin
					if (cmd_wr & (wbyte == `KCGRC_CMD_IF_TEST)) begin
						tst_r       <= kcgrc_pkg::KCGRC_TST_RUN;
						tst_phase_r <= 2'd0;
						tst_cnt_r   <= `KCGRC_TEST_SETTLE;
					end
				end
				kcgrc_pkg::KCGRC_TST_RUN: begin
					if (tst_cnt_r != 4'h0) begin
						tst_cnt_r <= tst_cnt_r - 4'h1;
					end else begin
						tst_cnt_r   <= `KCGRC_TEST_SETTLE;
						tst_phase_r <= tst_phase_r + 2'd1;
						unique case (tst_phase_r)
							2'd0: begin
								kclk_oe <= pins_s2_r.kclk;
								if (!pins_s2_r.kclk) begin
									tst_res_r <= `KCGRC_TST_CLK_LOW;
								end
							end
							2'd1: begin
								kclk_oe <= 1'b0;
								if (pins_s2_r.kclk) begin
									tst_res_r <= `KCGRC_TST_CLK_HIGH;
								end
							end
							2'd2: begin
								kdat_oe <= pins_s2_r.kdat;
								if (!pins_s2_r.kdat) begin
									tst_res_r <= `KCGRC_TST_DAT_LOW;
								end
							end
							2'd3: begin
								kdat_oe <= 1'b0;
								tst_res_r <= pins_s2_r.kdat ? `KCGRC_TST_DAT_HIGH : `KCGRC_TST_OK;
							end
						endcase
						// Stop at the first fault or after the last phase
						if ((tst_phase_r == 2'd3) ||
						    ((tst_phase_r == 2'd0) & ~pins_s2_r.kclk) ||
						    ((tst_phase_r == 2'd1) & pins_s2_r.kclk) ||
						    ((tst_phase_r == 2'd2) & ~pins_s2_r.kdat)) begin
							tst_r      <= kcgrc_pkg::KCGRC_TST_IDLE;
							tst_done_r <= 1'b1;
							kclk_oe    <= 1'b0;
							kdat_oe    <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// Open drain: only ever pull low
	always_ff @(posedge mclk) begin
		kclk_out <= 1'b0;
		kdat_out <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Reset pulse channels
	// ------------------------------------------------------------------
	// 0: hardware FE reset, 1: fast port reset, 2: even Fx reset line
	assign pulse_trig[0] = cmd_wr & (wbyte == `KCGRC_CMD_HW_RESET);
	assign pulse_trig[1] = wr_fire & hit_port & wbyte[`KCGRC_RST_BIT] &
	                       ~fast_port_r[`KCGRC_RST_BIT] &
	                       fast_ctl_r[`KCGRC_CTL_PORT_EN];
	assign pulse_trig[2] = cmd_wr & (wbyte[7:4] == `KCGRC_CMD_PULSE_HI) & ~wbyte[0];

	generate
		for (genvar g = 0; g < 3; g++) begin : g_pulse
			localparam logic [11:0] DLY = (g == 2) ? 12'd0 : 12'(`KCGRC_RST_DELAY_CYC);
			localparam logic [11:0] LEN = 12'(`KCGRC_RST_PULSE_CYC);
			logic        busy_r;
			logic        low_r;
			logic [11:0] cnt_r;

			// Delay phase (channels 0 and 1 only) then low phase; a trigger while busy is ignored
			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					busy_r <= 1'b0;
					low_r  <= 1'b0;
					cnt_r  <= 12'h000;
				end else if (!busy_r) begin
					if (pulse_trig[g]) begin
						busy_r <= 1'b1;
						low_r  <= (DLY == 12'd0);
						cnt_r  <= (DLY == 12'd0) ? LEN - 12'd1 : DLY - 12'd1;
					end
				end else if (cnt_r != 12'h000) begin
					cnt_r <= cnt_r - 12'h001;
				end else if (!low_r) begin
					low_r <= 1'b1;
					cnt_r <= LEN - 12'd1;
				end else begin
					busy_r <= 1'b0;
					low_r  <= 1'b0;
				end
			end

			assign pulse_low[g] = low_r;
		end
	endgenerate

	// ------------------------------------------------------------------
	// Gate and reset outputs
	// ------------------------------------------------------------------
	// Hardware or firmware owns each output, never both; the fast port
	// is ORed in when enabled, so firmware cannot override its request.
	always_comb begin
		gate_nxt = fast_ctl_r[`KCGRC_CTL_HW_GATE] ? port_two_r[`KCGRC_GATE_BIT]
		                                          : fw_r[`KCGRC_GATE_BIT];
		gate_nxt = gate_nxt | (fast_ctl_r[`KCGRC_CTL_PORT_EN] &
		                       fast_port_r[`KCGRC_GATE_BIT]);
		rst_low_nxt = fast_ctl_r[`KCGRC_CTL_HW_RST] ?
		              (~port_two_r[`KCGRC_RST_BIT] | pulse_low[0]) :
		              ~fw_r[`KCGRC_RST_BIT];
		rst_low_nxt = rst_low_nxt | (fast_ctl_r[`KCGRC_CTL_PORT_EN] & pulse_low[1]);
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			addr_line20_gate   <= 1'b0;
			keyboard_reset_out <= 1'b1;
			reset_line         <= 1'b1;
			clk_rate_sel       <= 2'b00;
		end else begin
			addr_line20_gate   <= gate_nxt;
			keyboard_reset_out <= ~rst_low_nxt;
			reset_line         <= ~pulse_low[2];
			clk_rate_sel       <= fast_ctl_r[`KCGRC_CTL_RATE_HI:`KCGRC_CTL_RATE_LO];
		end
	end

endmodule

// *** testbench/kcgrc_assertions.sv ***
module kcgrc_assertions (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// APB side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Outputs watched
	input wire logic        kclk_out,
	input wire logic        kdat_out,
	input wire kcgrc_pkg::kcgrc_byte_t aux_tx,
	input wire logic [1:0]  clk_rate_sel,
	input wire logic        reset_line
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Write strobes at the edge where the slave answers
	logic [11:0] low_r;
	wire acc = psel && penable && pready && pwrite;
	wire wr_ctl = acc && paddr == 8'hf0;
	wire wr_dat = acc && paddr == 8'h00;
	wire wr_fx = acc && paddr == 8'h04 && pwdata[7:4] == 4'hf && !pwdata[0];
	// Low time of the reset line; too long for a repetition
	always_ff @(posedge mclk) begin
		if (!reset_n || reset_line) begin
			low_r <= 12'h000;
		end else begin
			low_r <= low_r + 12'h001;
		end
	end
	property p_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("pready not in second access cycle");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("pready longer than one cycle");
	property p_err; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
	a_err: assert property (p_err) else $error("bad error response");
	property p_fix; pready && !pwrite && !pslverr && paddr == 8'h0c |-> prdata[7:2] == 6'h09; endproperty
	a_fix: assert property (p_fix) else $error("fixed port bits wrong");
	property p_rate; $changed(clk_rate_sel) |-> $past(wr_ctl) || $past(wr_ctl, 2); endproperty
	a_rate: assert property (p_rate) else $error("rate select moved alone");
	property p_rl_len; $rose(reset_line) |-> low_r == 12'h4b0; endproperty
	a_rl_len: assert property (p_rl_len) else $error("reset line pulse length");
	property p_rl_go; $fell(reset_line) |-> $past(wr_fx) || $past(wr_fx, 2); endproperty
	a_rl_go: assert property (p_rl_go) else $error("reset line fell alone");
	property p_od; !kclk_out && !kdat_out; endproperty
	a_od: assert property (p_od) else $error("open drain line driven high");
	property p_aux; aux_tx.valid |-> ($past(wr_dat) || $past(wr_dat, 2)) ##1 !aux_tx.valid; endproperty
	a_aux: assert property (p_aux) else $error("aux byte without data write");
endmodule

// *** testbench/kcgrc_pins_model.sv ***
module kcgrc_pins_model (
	// Line drive from the controller
	input  wire logic              kclk_out,
	input  wire logic              kclk_oe,
	input  wire logic              kdat_out,
	input  wire logic              kdat_oe,
	// Fault: 1/2 clock stuck low/high, 3/4 data stuck low/high
	input  wire logic [2:0]        fault,
	input  wire logic [7:0]        port_val,
	input  wire logic [1:0]        test_val,
	// Pin group
	output kcgrc_pkg::kcgrc_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pulled-up lines; a stuck fault wins over any drive
	wire kc = kclk_oe ? kclk_out : 1'b1;
	wire kd = kdat_oe ? kdat_out : 1'b1;
	wire kcf = (fault == 3'd1) ? 1'b0 : (fault == 3'd2) ? 1'b1 : kc;
	wire kdf = (fault == 3'd3) ? 1'b0 : (fault == 3'd4) ? 1'b1 : kd;
	assign pins = {port_val, test_val, kcf, kdf};
endmodule

// *** testbench/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0, pv = 8'ha5, kb_seen = 0, aux_seen = 0;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic        pready, pslverr, rerr, kclk_out, kclk_oe, kdat_out, kdat_oe, gate, kbr, rl;
	logic [1:0]  crs, tv = 0;
	logic [2:0]  flt = 0;
	kcgrc_pkg::kcgrc_pins_t pins;
	kcgrc_pkg::kcgrc_byte_t kb_tx, aux_tx;
	int          bad_count = 0, total_checks = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	kcgrc_top kcgrc_top_inst (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pins_in(pins), .kclk_out, .kclk_oe, .kdat_out, .kdat_oe,
		.kb_tx, .aux_tx, .clk_rate_sel(crs), .addr_line20_gate(gate),
		.keyboard_reset_out(kbr), .reset_line(rl));
	kcgrc_pins_model kcgrc_pins_model_inst (.kclk_out, .kclk_oe, .kdat_out, .kdat_oe,
		.fault(flt), .port_val(pv), .test_val(tv), .pins);
	// Valid lasts one cycle, so keep the last byte of each link
	always @(posedge mclk) begin
		if (kb_tx.valid) kb_seen <= kb_tx.data;
		if (aux_tx.valid) aux_seen <= aux_tx.data;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// APB transfer; waits for pready with no bound of its own
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		// Only the cycle ceiling ends a wait for pready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 8'h00);
		chk(nm, rdat, e);
	endtask
	// Delayed keyboard reset pulse
	task automatic pulse();
		wt(2698);
		chk("kbr", 32'(kbr), 32'h1);
		wt(200);
		chk("kbr", 32'(kbr), 32'h0);
		wt(1200);
		chk("kbr", 32'(kbr), 32'h1);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		wt(4);
		reset_n <= 1'b1;
		chk("kbr", 32'(kbr), 32'h1);
		wr(8'h0c, 8'hfc);
		rc(8'h0c, 32'h24, "fport");
		rc(8'h08, 32'h1, "fw");
		rc(8'h40, 32'h0, "unmapped");
		chk("err", 32'(rerr), 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(8'hf0, {i[1:0], 6'h3f});
			rc(8'hf0, {24'h0, i[1:0], 6'h07}, "ctl");
			chk("rate", 32'(crs), 32'(i));
		end
		wr(8'hf0, 8'h00);
		wr(8'h00, 8'h11);
		wt(3);
		chk("kb", 32'(kb_seen), 32'h11);
		wr(8'h04, 8'hc0);
		rc(8'h00, 32'ha5, "p1");
		wr(8'h04, 8'hc1);
		xfer(1'b0, 8'h04, 8'h00);
		chk("lo", 32'(rdat[7:4]), 32'h5);
		pv <= 8'h3c;
		wt(4);
		xfer(1'b0, 8'h04, 8'h00);
		chk("lo", 32'(rdat[7:4]), 32'hc);
		wr(8'h04, 8'hc2);
		xfer(1'b0, 8'h04, 8'h00);
		chk("hi", 32'(rdat[7:4]), 32'h3);
		wr(8'h04, 8'hd0);
		rc(8'h00, 32'h1, "p2");
		for (int i = 0; i < 2; i++) begin
			wr(8'h04, 8'hd2 + 8'(i));
			wr(8'h00, 8'h5a + 8'(i));
			xfer(1'b0, 8'h04, 8'h00);
			chk("st", 32'({rdat[5], rdat[0]}), 32'(2 * i + 1));
			rc(8'h00, 32'h5a + 32'(i), "echo");
		end
		wr(8'h04, 8'hd4);
		wr(8'h00, 8'h77);
		wt(3);
		chk("aux", 32'(aux_seen), 32'h77);
		tv <= 2'b10;
		wt(4);
		wr(8'h04, 8'he0);
		xfer(1'b0, 8'h00, 8'h00);
		chk("tin", 32'(rdat[1:0]), 32'h2);
		for (int f = 0; f < 5; f++) begin
			flt <= 3'(f);
			wr(8'h04, 8'hab);
			wt(50);
			rc(8'h00, 32'(f), "iftest");
		end
		flt <= 3'd0;
		wr(8'hf0, 8'h03);
		for (int i = 0; i < 2; i++) begin
			wr(8'h04, 8'hd1);
			wr(8'h00, 8'h02 - 8'(i));
			wt(3);
			chk("gate", 32'(gate), 32'(1 - i));
			chk("kbr", 32'(kbr), 32'(i));
			wr(8'h04, 8'hd0);
			rc(8'h00, 32'h2 - 32'(i), "p2");
		end
		wr(8'h04, 8'hfe);
		wt(2);
		chk("rl", 32'(rl), 32'h0);
		pulse();
		wr(8'h04, 8'hf1);
		wt(5);
		chk("rl", 32'(rl), 32'h1);
		wr(8'hf0, 8'h00);
		wr(8'h08, 8'h02);
		wt(3);
		chk("gate", 32'(gate), 32'h1);
		chk("kbr", 32'(kbr), 32'h0);
		wr(8'h08, 8'h01);
		wr(8'h0c, 8'h02);
		wt(3);
		chk("gate", 32'(gate), 32'h0);
		chk("kbr", 32'(kbr), 32'h1);
		wr(8'hf0, 8'h04);
		wt(3);
		chk("gate", 32'(gate), 32'h1);
		wr(8'h0c, 8'h01);
		pulse();
		chk("gate", 32'(gate), 32'h0);
		wr(8'h0c, 8'h00);
		stop_test();
	end
endmodule
bind kcgrc_top kcgrc_assertions kcgrc_assertions_inst (.mclk, .reset_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .kclk_out, .kdat_out, .aux_tx,
	.clk_rate_sel, .reset_line);
